// >>> rtl/adc_control_sequencer.sv
// Control sequencer of a four-channel successive conversion converter
`timescale 1ns/1ps
`include "adc_control_sequencer_params.svh"

module adc_control_sequencer #(
  parameter int RES_BITS = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire adc_control_sequencer_pkg::reg_req_t i_reg,
  output logic [7:0] o_reg_rdata,
  input wire adc_control_sequencer_pkg::samples_t i_samples,
  input wire logic i_conv_irq_en,
  output logic [1:0] o_sample_channel,
  output logic [3:0] o_analog_pin_en,
  output logic o_adc_power_on,
  output logic o_conv_flag_set,
  output logic o_conv_irq
);

  // Only the three supported widths have a known period count
  if (RES_BITS != 8 && RES_BITS != 9 && RES_BITS != 12) begin : g_bad_res
    $error("RES_BITS must be 8, 9 or 12");
  end

  // Number of conversion clock periods in one conversion
  function automatic logic [6:0] conv_periods(input int res);
    if (res == 8) begin
      return `CONV_PERIODS_8;
    end else if (res == 9) begin
      return `CONV_PERIODS_9;
    end
    return `CONV_PERIODS_12;
  endfunction

  // Divider field to log2 of the ratio; unused codes take the slowest
  function automatic logic [2:0] div_shift(input logic [2:0] code);
    case (code)
      3'h4: return 3'h0;
      3'h0: return 3'h1;
      3'h5: return 3'h2;
      3'h1: return 3'h3;
      3'h6: return 3'h4;
      default: return 3'h5;
    endcase
  endfunction

  localparam logic [6:0] PERIODS = conv_periods(RES_BITS);

  adc_control_sequencer_pkg::conv_control_t ctrl;
  adc_control_sequencer_pkg::conv_state_t state;
  adc_control_sequencer_pkg::conv_state_t next_state;
  logic busy;
  logic [2:0] clock_divider_select;
  logic [15:0] result;
  logic [4:0] div_cnt;
  logic [6:0] period_cnt;

  wire [1:0] chan = ctrl.channel_select[1:0];
  wire powered = ctrl.pin_config != `PIN_CONFIG_OFF;
  wire [2:0] shift = div_shift(clock_divider_select);
  wire [4:0] div_mask = 5'((6'h01 << shift) - 6'h01);
  wire tick = (div_cnt & div_mask) == div_mask;
  wire converting = state == adc_control_sequencer_pkg::ST_CONVERT;
  wire finish = converting && !ctrl.start && powered &&
                tick && period_cnt == PERIODS - 7'h01;
  wire wr_ctrl = i_reg.wr && i_reg.addr == `CONV_CONTROL_ADDR;
  wire wr_clk = i_reg.wr && i_reg.addr == `CONV_CLOCK_SELECT_ADDR;
  wire [11:0] picked = i_samples.ch[chan];
  wire [15:0] justified = 16'({4'h0, picked[RES_BITS-1:0]} <<
                              (16 - RES_BITS));
  wire [3:0] pin_decode =
    ctrl.pin_config >= `PIN_CONFIG_ALL ? 4'hF :
    4'((5'h01 << ctrl.pin_config) - 5'h01);
  wire [7:0] ctrl_read = {ctrl.start, busy, ctrl.pin_config,
                          ctrl.channel_select};
  wire [7:0] read_mux =
    i_reg.addr == `CONV_CONTROL_ADDR ? ctrl_read :
    i_reg.addr == `CONV_CLOCK_SELECT_ADDR ?
      {5'h00, clock_divider_select} :
    i_reg.addr == `CONV_RESULT_HIGH_ADDR ? result[15:8] : result[7:0];

  // Start high holds reset; its fall launches the conversion if powered, else returns to idle
  always_comb begin
    next_state = state;
    unique case (state)
      adc_control_sequencer_pkg::ST_IDLE: begin
        if (ctrl.start) begin
          next_state = adc_control_sequencer_pkg::ST_HOLD;
        end
      end
      adc_control_sequencer_pkg::ST_HOLD: begin
        if (!ctrl.start && powered) begin
          next_state = adc_control_sequencer_pkg::ST_CONVERT;
        end else if (!ctrl.start) begin
          next_state = adc_control_sequencer_pkg::ST_IDLE;
        end
      end
      adc_control_sequencer_pkg::ST_CONVERT: begin
        if (ctrl.start) begin
          next_state = adc_control_sequencer_pkg::ST_HOLD;
        end else if (!powered || finish) begin
          next_state = adc_control_sequencer_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl <= `CONV_CONTROL_RESET;
      clock_divider_select <= `CONV_CLOCK_SELECT_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {i_reg.wdata[`CTRL_START_BIT],
                 i_reg.wdata[`CTRL_PIN_LSB +: 3],
                 i_reg.wdata[`CTRL_CHAN_LSB +: 3]};
      end
      if (wr_clk) begin
        clock_divider_select <= i_reg.wdata[2:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= adc_control_sequencer_pkg::ST_IDLE;
      busy <= `CONV_BUSY_RESET;
    end else begin
      state <= next_state;
      if (ctrl.start) begin
        busy <= 1'b1;
      end else if (finish) begin
        busy <= 1'b0;
      end
    end
  end

  // Divider and period count restart with every conversion
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !converting) begin
      div_cnt <= 5'h00;
      period_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
      if (tick) begin
        period_cnt <= period_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      result <= 16'h0000;
      o_reg_rdata <= 8'h00;
      o_conv_flag_set <= 1'b0;
      o_conv_irq <= 1'b0;
      o_analog_pin_en <= 4'h0;
      o_adc_power_on <= 1'b0;
      o_sample_channel <= 2'h0;
    end else begin
      if (finish) begin
        result <= justified;
      end
      if (i_reg.rd) begin
        o_reg_rdata <= read_mux;
      end
      o_conv_flag_set <= finish;
      o_conv_irq <= finish && i_conv_irq_en;
      o_analog_pin_en <= pin_decode;
      o_adc_power_on <= powered;
      o_sample_channel <= chan;
    end
  end

  // Helper: cycles spent converting, and whether the divider moved
  logic [11:0] cyc_cnt;
  logic div_moved;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !converting) begin
      cyc_cnt <= 12'h000;
      div_moved <= wr_clk;
    end else begin
      cyc_cnt <= cyc_cnt + 12'h001;
      div_moved <= div_moved | wr_clk;
    end
  end

  chk_busy_held: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    ctrl.start |=> busy && state == adc_control_sequencer_pkg::ST_HOLD)
    else $error("busy not set while start held");

  chk_done_clears: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    finish |=> !busy && o_conv_flag_set ##1 !o_conv_flag_set)
    else $error("completion did not clear busy once");

  chk_irq_gating: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_conv_irq |-> o_conv_flag_set && $past(i_conv_irq_en))
    else $error("interrupt without completion or enable");

  chk_irq_raised: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    finish && i_conv_irq_en |=> o_conv_irq)
    else $error("enabled completion raised no interrupt");

  chk_conv_length: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    finish && !div_moved && !wr_clk |->
      cyc_cnt == 12'({5'h00, PERIODS} << shift) - 12'h001)
    else $error("conversion length wrong");

  chk_result_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !finish |=> $stable(result))
    else $error("result changed without completion");

  chk_result_map: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    finish |=> result[15:16-RES_BITS] ==
      $past(i_samples.ch[chan][RES_BITS-1:0]) &&
      result[15-RES_BITS:0] == '0)
    else $error("result not left-justified from selected channel");

  chk_pins_all: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    ctrl.pin_config >= `PIN_CONFIG_ALL |=> o_analog_pin_en == 4'hF)
    else $error("not all pins analog");

  // A powered-down cycle never leads straight into a conversion
  chk_power_down: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    ctrl.pin_config == `PIN_CONFIG_OFF |=>
      !o_adc_power_on && o_analog_pin_en == 4'h0 && !converting)
    else $error("converter not powered down");

  chk_busy_write: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !ctrl.start && !finish |=> $stable(busy))
    else $error("busy moved without start or completion");

endmodule

// >>> rtl/adc_control_sequencer_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_CONTROL_SEQUENCER_PARAMS_SVH
`define ADC_CONTROL_SEQUENCER_PARAMS_SVH

`define CONV_CONTROL_ADDR 2'h0
`define CONV_CLOCK_SELECT_ADDR 2'h1
`define CONV_RESULT_HIGH_ADDR 2'h2
`define CONV_RESULT_LOW_ADDR 2'h3

`define CTRL_START_BIT 7
`define CTRL_BUSY_BIT 6
`define CTRL_PIN_LSB 3
`define CTRL_CHAN_LSB 0

`define CONV_CONTROL_RESET 7'h00
`define CONV_CLOCK_SELECT_RESET 3'h0
`define CONV_BUSY_RESET 1'b0

`define PIN_CONFIG_OFF 3'h0
`define PIN_CONFIG_ALL 3'h4

`define CONV_PERIODS_8 7'h40
`define CONV_PERIODS_9 7'h4C
`define CONV_PERIODS_12 7'h50

`endif

// >>> rtl/adc_control_sequencer_pkg.sv
// Types shared by the converter control sequencer
package adc_control_sequencer_pkg;

  typedef logic [11:0] sample_t;

  typedef struct packed {
    sample_t [3:0] ch;
  } samples_t;

  typedef struct packed {
    logic start;
    logic [2:0] pin_config;
    logic [2:0] channel_select;
  } conv_control_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_CONVERT
  } conv_state_t;

endpackage

// >>> sim/adc_control_sequencer_tb.sv
// Self-checking bench of the converter control sequencer
`timescale 1ns/1ps
module adc_control_sequencer_tb;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  adc_control_sequencer_pkg::reg_req_t i_reg = '0;
  adc_control_sequencer_pkg::samples_t i_samples = '0;
  logic i_conv_irq_en = 1'b0;
  logic [7:0] o_reg_rdata;
  logic [1:0] o_sample_channel;
  logic [3:0] o_analog_pin_en;
  logic o_adc_power_on;
  logic o_conv_flag_set;
  logic o_conv_irq;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] q_rd[$];
  logic q_irq[$];
  logic pend = 1'b0;
  logic [11:0] prev = 12'h000;

  always #2.5 i_mclk = ~i_mclk;

  adc_control_sequencer #(.RES_BITS(12)) dut (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_reg(i_reg),
    .o_reg_rdata(o_reg_rdata),
    .i_samples(i_samples),
    .i_conv_irq_en(i_conv_irq_en),
    .o_sample_channel(o_sample_channel),
    .o_analog_pin_en(o_analog_pin_en),
    .o_adc_power_on(o_adc_power_on),
    .o_conv_flag_set(o_conv_flag_set),
    .o_conv_irq(o_conv_irq)
  );

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_mclk);
    i_reg <= '0;
  endtask

  // Expected read data is queued; the monitor compares it a cycle later
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    q_rd.push_back(e);
    @(posedge i_mclk);
    i_reg <= '0;
  endtask

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      close_out();
    end else begin
      if (pend) begin
        check("rdata", 16'(o_reg_rdata), 16'(q_rd.pop_front()));
      end
      if (o_conv_flag_set === 1'b1) begin
        if (q_irq.size() == 0) begin
          check("flag", 16'h0001, 16'h0000);
        end else begin
          check("irq", 16'(o_conv_irq), 16'(q_irq.pop_front()));
        end
      end
      pend = i_reg.rd;
    end
  end

  // Control byte: start, busy, pin config 100, channel field with MSB 0
  task automatic convert(input logic [2:0] code, input int div,
                         input logic en);
    int n;
    logic [11:0] s;
    logic [1:0] ch;
    s = 12'($urandom);
    ch = 2'($urandom_range(3));
    i_samples.ch[ch] <= s;
    i_conv_irq_en <= en;
    wr(2'h1, {5'h00, code});
    wr(2'h0, {5'b00100, 1'b0, ch});
    wr(2'h0, {5'b10100, 1'b0, ch});
    repeat (2) @(posedge i_mclk);
    rd(2'h0, {5'b11100, 1'b0, ch});
    q_irq.push_back(en);
    wr(2'h0, {5'b01100, 1'b0, ch});
    rd(2'h2, prev[11:4]);
    n = 2;
    while (o_conv_flag_set !== 1'b1 && n < 3000) begin
      @(posedge i_mclk);
      n++;
    end
    // Entering the conversion and launching the pulse add one edge each
    check("length", 16'(n), 16'(80 * div + 2));
    check("channel", 16'(o_sample_channel), 16'(ch));
    rd(2'h0, {5'b00100, 1'b0, ch});
    rd(2'h2, s[11:4]);
    rd(2'h3, {s[3:0], 4'h0});
    prev = s;
  endtask

  initial begin
    logic [2:0] codes[6];
    logic [7:0] pins;
    // Samples are digital here, so fast conversion clocks are harmless
    codes = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2};
    void'($urandom(42263));
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(2'h0, {2'b00, 3'(c), 3'b000});
      // Pin enables follow the control register one edge later
      repeat (2) @(posedge i_mclk);
      pins = (c == 0) ? 8'h00 : (c >= 4) ? 8'h0F : (8'h01 << c) - 8'h01;
      check("pins", 16'(o_analog_pin_en), 16'(pins));
      check("power", 16'(o_adc_power_on), 16'(c != 0));
    end
    wr(2'h1, 8'hFC);
    rd(2'h1, 8'h04);
    wr(2'h2, 8'h55);
    rd(2'h2, 8'h00);
    wr(2'h0, 8'h40);
    rd(2'h0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      convert(codes[i], 1 << i, 1'(i));
    end
    repeat (4) @(posedge i_mclk);
    close_out();
  end
endmodule
